// >>> rtl/spfmt_pkg.sv
// constants and helpers shared by the serial port frame-format block
package spfmt_pkg;

   // ==========================================================
   // register offsets (byte addresses, one aligned word each)
   localparam logic [7:0] OFS_RX_CTRL = 8'h00;
   localparam logic [7:0] OFS_TX_CTRL = 8'h04;
   localparam logic [7:0] OFS_TX_DATA = 8'h08;
   localparam logic [7:0] OFS_RX_DATA = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   // ==========================================================
   // reset values of both control words and the transmit data word; writable bits of both control words
   localparam logic [31:0] RX_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] TX_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] TX_DATA_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL_WR_MASK = 32'hffff_7ff0;

   // ==========================================================
   // field positions inside a control word
   localparam int PHASE_BIT = 31;
   localparam int FRLEN2_LSB = 24;
   localparam int WDLEN2_LSB = 21;
   localparam int COMP_LSB = 19;
   localparam int FIG_BIT = 18;
   localparam int DLY_LSB = 16;
   localparam int FRLEN1_LSB = 8;
   localparam int WDLEN1_LSB = 5;
   localparam int REV_BIT = 4;

   // status word bit positions
   localparam int ST_TX_EMPTY = 0;
   localparam int ST_RX_READY = 1;
   localparam int ST_RX_BUSY = 2;
   localparam int ST_TX_BUSY = 3;

   // ==========================================================
   // codes
   localparam logic [2:0] WDLEN_8 = 3'h0;
   localparam logic [1:0] COMP_LSB_FIRST = 2'h1;
   localparam logic [1:0] COMP_MULAW = 2'h2;
   localparam logic [13:0] MU_BIAS = 14'h0021;
   localparam logic [13:0] MU_CLIP = 14'h1fde;
   localparam logic [5:0] WORD_MAX_BITS = 6'h20;

   // frame engine states, shared by both directions
   typedef enum logic [1:0] {SPF_IDLE, SPF_DELAY, SPF_SHIFT} spfmt_state_t;

   // word-length code to bits per word; reserved codes fall back to 8
   function automatic logic [5:0] spfmt_wl_bits(input logic [2:0] code);
      case (code)
         3'h0: spfmt_wl_bits = 6'h08;
         3'h1: spfmt_wl_bits = 6'h0c;
         3'h2: spfmt_wl_bits = 6'h10;
         3'h3: spfmt_wl_bits = 6'h14;
         3'h4: spfmt_wl_bits = 6'h18;
         3'h5: spfmt_wl_bits = 6'h20;
         default: spfmt_wl_bits = 6'h08;
      endcase
   endfunction

endpackage

// >>> rtl/spfmt_top.sv
// serial port frame-format engine with its ahb-lite register slave
// What this block does
// RULE_01 - receive phase-1 word length code sets bits
// RULE_02 - receive reversal bit takes 32-bit words LSB-first
// RULE_03 - software pairs reversal with length 5h, compand 1h
// RULE_04 - reserved bits read zero, ignore writes
// RULE_05 - transmit phase bit picks single or dual phase
// RULE_06 - phase-2 frame length is field plus one words
// RULE_07 - phase-1 frame length is field plus one words
// RULE_08 - phase-2 transmit word length code sets bits
// RULE_09 - companding only with 8-bit transmit words
// RULE_10 - compand field: msb, lsb, mu-law, a-law
// RULE_11 - frame ignore bit drops later frame syncs
// RULE_12 - data delay of 0, 1 or 2 bit clocks
// RULE_13 - phase-1 transmit word length code sets bits
// RULE_14 - transmit reversal sends 32-bit words LSB-first
// RULE_15 - single phase uses only phase-1 settings
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module spfmt_top (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic [31:0] o_hrdata,
   output logic o_hresp,
   // serial link
   input wire logic i_bclk,
   input wire logic i_fsx,
   input wire logic i_fsr,
   input wire logic i_dr,
   output logic o_dx,
   output logic o_dx_drive
);
   import spfmt_pkg::*;

   // ==========================================================
   // helpers
   function automatic logic [31:0] rev32(input logic [31:0] w);
      rev32 = 32'h0000_0000;
      for (int i = 0; i < 32; i++) begin
         rev32[i] = w[31 - i];
      end
   endfunction

   // mu-law: 14-bit magnitude with bias, segment from the top set bit
   function automatic logic [7:0] mulaw_enc(input logic [15:0] lin);
      logic [15:0] mag;
      logic [13:0] m;
      logic [2:0] seg;
      logic [3:0] mant;
      mag = lin[15] ? (~lin + 16'h0001) : lin;
      m = (mag[15:2] > MU_CLIP) ? MU_CLIP : mag[15:2];
      m = m + MU_BIAS;
      seg = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (m[i + 5]) begin
            seg = 3'(i);
         end
      end
      mant = 4'(m >> ({1'b0, seg} + 4'h1));
      mulaw_enc = {1'b0, seg, mant} ^ (lin[15] ? 8'h7f : 8'hff);
   endfunction

   // a-law: 13-bit magnitude, segment 0 keeps the linear region
   function automatic logic [7:0] alaw_enc(input logic [15:0] lin);
      logic [15:0] mag;
      logic [12:0] m;
      logic [2:0] seg;
      logic [3:0] mant;
      mag = lin[15] ? (~lin + 16'h0001) : lin;
      m = mag[15:3];
      seg = 3'h0;
      for (int i = 1; i < 8; i++) begin
         if (m[i + 4]) begin
            seg = 3'(i);
         end
      end
      mant = (seg == 3'h0) ? m[4:1] : 4'(m >> seg);
      alaw_enc = {1'b0, seg, mant} ^ (lin[15] ? 8'h55 : 8'hd5);
   endfunction

   // ==========================================================
   // link input synchronisers; stage two feeds logic, and the bit clock's stage three feeds its edge detect
   logic bclk_s1_q, bclk_s2_q, bclk_s3_q;
   logic fsx_s1_q, fsx_s2_q, fsx_prev_q;
   logic fsr_s1_q, fsr_s2_q, fsr_prev_q;
   logic dr_s1_q, dr_s2_q;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         {bclk_s1_q, bclk_s2_q, bclk_s3_q} <= 3'h0;
         {fsx_s1_q, fsx_s2_q, fsr_s1_q, fsr_s2_q} <= 4'h0;
         {dr_s1_q, dr_s2_q} <= 2'h0;
      end else begin
         bclk_s1_q <= i_bclk;
         bclk_s2_q <= bclk_s1_q;
         bclk_s3_q <= bclk_s2_q;
         fsx_s1_q <= i_fsx;
         fsx_s2_q <= fsx_s1_q;
         fsr_s1_q <= i_fsr;
         fsr_s2_q <= fsr_s1_q;
         dr_s1_q <= i_dr;
         dr_s2_q <= dr_s1_q;
      end
   end

   // bit clock edges; frame syncs are looked at on falling edges only
   wire bclk_rise = bclk_s2_q & ~bclk_s3_q;
   wire bclk_fall = ~bclk_s2_q & bclk_s3_q;
   wire fsx_edge = bclk_fall & fsx_s2_q & ~fsx_prev_q;
   wire fsr_edge = bclk_fall & fsr_s2_q & ~fsr_prev_q;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         fsx_prev_q <= 1'b0;
         fsr_prev_q <= 1'b0;
      end else if (bclk_fall) begin
         fsx_prev_q <= fsx_s2_q;
         fsr_prev_q <= fsr_s2_q;
      end
   end

   // ==========================================================
   // ahb-lite slave: zero wait states, read data registered
   logic [31:0] rx_ctrl_q, tx_ctrl_q, tx_data_q, rx_data_q;
   logic tx_empty_q, rx_ready_q;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   spfmt_state_t tx_state_q, rx_state_q;

   wire addr_ok = i_hsel & i_hready & i_htrans[1];
   wire rd_take = addr_ok & ~i_hwrite;
   wire wr_take = addr_ok & i_hwrite;
   wire rd_rx_data = rd_take & (i_haddr[7:0] == OFS_RX_DATA);
   wire wr_rx_ctrl = wr_pend_q & (wr_addr_q == OFS_RX_CTRL);
   wire wr_tx_ctrl = wr_pend_q & (wr_addr_q == OFS_TX_CTRL);
   wire wr_tx_data = wr_pend_q & (wr_addr_q == OFS_TX_DATA);
   wire [31:0] status_w = {28'h0, tx_state_q != SPF_IDLE, rx_state_q != SPF_IDLE,
                           rx_ready_q, tx_empty_q};

   // unmapped reads give zero; unmapped, status and receive-data writes vanish
   logic [31:0] rd_mux;
   always_comb begin
      case (i_haddr[7:0])
         OFS_RX_CTRL: rd_mux = rx_ctrl_q;
         OFS_TX_CTRL: rd_mux = tx_ctrl_q;
         OFS_TX_DATA: rd_mux = tx_data_q;
         OFS_RX_DATA: rd_mux = rx_data_q;
         OFS_STATUS: rd_mux = status_w;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         o_hrdata <= 32'h0000_0000;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         wr_pend_q <= wr_take;
         if (wr_take) begin
            wr_addr_q <= i_haddr[7:0];
         end
         if (rd_take) begin
            o_hrdata <= rd_mux;
         end
      end
   end

   // control words: reserved bits 15 and 3..0 never store
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rx_ctrl_q <= RX_CTRL_RST;
         tx_ctrl_q <= TX_CTRL_RST;
         tx_data_q <= TX_DATA_RST;
      end else begin
         if (wr_rx_ctrl) begin
            rx_ctrl_q <= i_hwdata & CTRL_WR_MASK; // RULE_04
         end
         if (wr_tx_ctrl) begin
            tx_ctrl_q <= i_hwdata & CTRL_WR_MASK; // RULE_04
         end
         if (wr_tx_data) begin
            tx_data_q <= i_hwdata;
         end
      end
   end

   // ==========================================================
   // transmit field decode
   wire tx_dual = tx_ctrl_q[PHASE_BIT];
   wire [6:0] tx_frlen1 = tx_ctrl_q[FRLEN1_LSB +: 7];
   wire [6:0] tx_frlen2 = tx_ctrl_q[FRLEN2_LSB +: 7];
   wire [1:0] tx_comp = tx_ctrl_q[COMP_LSB +: 2];
   wire tx_fig = tx_ctrl_q[FIG_BIT];
   wire [1:0] tx_dly = tx_ctrl_q[DLY_LSB +: 2];
   wire tx_rev = tx_ctrl_q[REV_BIT];

   logic tx_p2_q;
   logic [6:0] tx_words_q;
   logic [5:0] tx_bits_q;
   logic [1:0] tx_dlycnt_q;
   logic [31:0] tx_sr_q;

   // a fresh sync starts a frame when idle; mid-frame only if not ignored
   wire tx_start = fsx_edge & ((tx_state_q == SPF_IDLE) | ~tx_fig); // RULE_11
   wire tx_word_end = (tx_state_q == SPF_SHIFT) & (tx_bits_q == 6'h00);
   wire tx_more = (tx_words_q != 7'h00) | (~tx_p2_q & tx_dual); // RULE_05 RULE_15
   wire tx_enter_p2 = tx_word_end & (tx_words_q == 7'h00);
   wire tx_load_p2 = tx_enter_p2 | tx_p2_q;
   wire tx_first = bclk_rise & ~tx_start & (tx_state_q == SPF_DELAY) & (tx_dlycnt_q == 2'h0);
   wire tx_next = bclk_rise & ~tx_start & tx_word_end & tx_more;
   wire tx_load = tx_first | tx_next;

   // word length of the word being loaded; phase 2 is reachable only when dual
   wire [2:0] tx_wl_code = tx_load_p2 ? tx_ctrl_q[WDLEN2_LSB +: 3] // RULE_08
                                      : tx_ctrl_q[WDLEN1_LSB +: 3]; // RULE_13
   wire [5:0] tx_len = spfmt_wl_bits(tx_wl_code);
   wire tx_is8 = tx_wl_code == WDLEN_8;
   wire tx_cmp_on = tx_is8 & tx_comp[1]; // RULE_09
   wire [7:0] tx_cmp_byte = (tx_comp == COMP_MULAW) ? mulaw_enc(tx_data_q[15:0])
                                                    : alaw_enc(tx_data_q[15:0]); // RULE_10
   wire [31:0] tx_src = tx_cmp_on ? {24'h0, tx_cmp_byte} : tx_data_q;
   wire tx_lsb = tx_rev | (tx_is8 & (tx_comp == COMP_LSB_FIRST)); // RULE_10 RULE_14
   // both bit orders are aligned so the next bit is always bit 31
   wire [31:0] tx_ld_word = tx_lsb ? rev32(tx_src) : (tx_src << (WORD_MAX_BITS - tx_len));

   // transmit engine: bits leave on bit clock rising edges
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tx_state_q <= SPF_IDLE;
         tx_p2_q <= 1'b0;
         tx_words_q <= 7'h00;
         tx_bits_q <= 6'h00;
         tx_dlycnt_q <= 2'h0;
         tx_sr_q <= 32'h0000_0000;
         o_dx <= 1'b0;
         o_dx_drive <= 1'b0;
      end else if (tx_start) begin
         tx_state_q <= SPF_DELAY;
         tx_p2_q <= 1'b0;
         tx_words_q <= tx_frlen1; // RULE_07
         tx_dlycnt_q <= tx_dly; // RULE_12
      end else if (tx_load) begin
         tx_state_q <= SPF_SHIFT;
         tx_p2_q <= tx_load_p2;
         if (tx_enter_p2) begin
            tx_words_q <= tx_frlen2; // RULE_06
         end else if (tx_next) begin
            tx_words_q <= tx_words_q - 7'h01;
         end
         tx_bits_q <= tx_len - 6'h01;
         tx_sr_q <= {tx_ld_word[30:0], 1'b0};
         o_dx <= tx_ld_word[31];
         o_dx_drive <= 1'b1;
      end else if (bclk_rise) begin
         case (tx_state_q)
            SPF_DELAY: begin
               tx_dlycnt_q <= tx_dlycnt_q - 2'h1; // RULE_12
            end
            SPF_SHIFT: begin
               if (tx_word_end) begin
                  tx_state_q <= SPF_IDLE;
                  o_dx_drive <= 1'b0;
               end else begin
                  tx_bits_q <= tx_bits_q - 6'h01;
                  tx_sr_q <= {tx_sr_q[30:0], 1'b0};
                  o_dx <= tx_sr_q[31];
               end
            end
            default: begin
               o_dx_drive <= 1'b0;
            end
         endcase
      end
   end

   // holding word empties as it is loaded; a same-cycle write wins
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tx_empty_q <= 1'b1;
      end else if (wr_tx_data) begin
         tx_empty_q <= 1'b0;
      end else if (tx_load) begin
         tx_empty_q <= 1'b1;
      end
   end

   // ==========================================================
   // receive field decode; only phase 1 framing is handled here
   wire [2:0] rx_wl_code = rx_ctrl_q[WDLEN1_LSB +: 3];
   wire [5:0] rx_len = spfmt_wl_bits(rx_wl_code); // RULE_01
   wire rx_rev = rx_ctrl_q[REV_BIT];
   wire [1:0] rx_comp = rx_ctrl_q[COMP_LSB +: 2];
   wire [1:0] rx_dly = rx_ctrl_q[DLY_LSB +: 2];
   wire rx_fig = rx_ctrl_q[FIG_BIT];
   // undefined unless software pairs reversal with 32 bits and lsb-first
   wire rx_lsb = rx_rev | ((rx_wl_code == WDLEN_8) & (rx_comp == COMP_LSB_FIRST)); // RULE_02 RULE_03

   logic [6:0] rx_words_q;
   logic [5:0] rx_cnt_q;
   logic [1:0] rx_dlycnt_q;
   logic [31:0] rx_sr_q;

   wire rx_start = fsr_edge & ((rx_state_q == SPF_IDLE) | ~rx_fig);
   wire rx_in_dly = rx_state_q == SPF_DELAY;
   wire rx_take = bclk_fall & (rx_start ? (rx_dly == 2'h0)
                  : ((rx_state_q == SPF_SHIFT) | (rx_in_dly & (rx_dlycnt_q == 2'h0))));
   wire [5:0] rx_cnt_eff = (rx_start | rx_in_dly) ? 6'h00 : rx_cnt_q;
   wire [6:0] rx_words_eff = rx_start ? rx_ctrl_q[FRLEN1_LSB +: 7] : rx_words_q;
   wire [31:0] rx_sr_d = {rx_sr_q[30:0], dr_s2_q};
   wire rx_done = rx_take & (rx_cnt_eff + 6'h01 == rx_len);
   // lsb-first words are flipped back, then right-justified
   wire [31:0] rx_word = rx_lsb ? (rev32(rx_sr_d) >> (WORD_MAX_BITS - rx_len)) // RULE_02
                                : (rx_sr_d & (32'hffff_ffff >> (WORD_MAX_BITS - rx_len)));

   // receive engine: bits are sampled on bit clock falling edges
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rx_state_q <= SPF_IDLE;
         rx_words_q <= 7'h00;
         rx_cnt_q <= 6'h00;
         rx_dlycnt_q <= 2'h0;
         rx_sr_q <= 32'h0000_0000;
         rx_data_q <= 32'h0000_0000;
      end else if (rx_take) begin
         rx_sr_q <= rx_sr_d;
         rx_cnt_q <= rx_done ? 6'h00 : rx_cnt_eff + 6'h01;
         rx_words_q <= rx_done ? rx_words_eff - 7'h01 : rx_words_eff;
         if (rx_done) begin
            rx_data_q <= rx_word;
            rx_state_q <= (rx_words_eff == 7'h00) ? SPF_IDLE : SPF_SHIFT;
         end else begin
            rx_state_q <= SPF_SHIFT;
         end
      end else if (rx_start) begin
         rx_state_q <= SPF_DELAY;
         rx_words_q <= rx_ctrl_q[FRLEN1_LSB +: 7];
         rx_dlycnt_q <= rx_dly - 2'h1;
      end else if (bclk_fall & rx_in_dly) begin
         rx_dlycnt_q <= rx_dlycnt_q - 2'h1;
      end
   end

   // ready flag: a word landing in the read cycle keeps it set
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rx_ready_q <= 1'b0;
      end else if (rx_done) begin
         rx_ready_q <= 1'b1;
      end else if (rd_rx_data) begin
         rx_ready_q <= 1'b0;
      end
   end

   // transfer size is not checked: every access is treated as a word
   wire unused_ok = &{1'b0, i_hsize, i_haddr[31:8]};

endmodule
`default_nettype wire

// >>> verif/spfmt_asserts.sv
// port-level assertions for the serial port frame-format block
`timescale 1ns/1ps
`default_nettype none
module spfmt_asserts
   import spfmt_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // bus and link ports watched
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic i_hready,
   input wire logic o_hreadyout,
   input wire logic [31:0] o_hrdata,
   input wire logic o_hresp,
   input wire logic i_bclk,
   input wire logic i_fsx,
   input wire logic o_dx,
   input wire logic o_dx_drive
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ==========================================================
   // helpers
   logic [5:0] fs_age_q;
   logic [5:0] fs_age_d;
   wire rd_take = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
   wire ctl_adr = (i_haddr[7:0] == OFS_RX_CTRL) || (i_haddr[7:0] == OFS_TX_CTRL);
   // cycles since frame sync was high, saturating so it never wraps back
   assign fs_age_d = i_fsx ? 6'h00 : ((fs_age_q == 6'h3f) ? fs_age_q : fs_age_q + 6'h01);
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         fs_age_q <= 6'h3f;
      end else begin
         fs_age_q <= fs_age_d;
      end
   end
   sequence rd_ctl_s;
      rd_take && ctl_adr;
   endsequence
   sequence rd_far_s;
      rd_take && (i_haddr[7:2] > 6'h04);
   endsequence
   // three low samples put us well clear of the resync delay
   sequence bclk_low_s;
      !i_bclk [*3];
   endsequence
   // ==========================================================
   // properties
   ready_high_a: assert property (o_hreadyout)
      else $error("hreadyout low");
   resp_okay_a: assert property (!o_hresp)
      else $error("hresp not okay");
   rsvd_zero_a: assert property (rd_ctl_s |=> !o_hrdata[15] && (o_hrdata[3:0] == 4'h0))
      else $error("reserved bits read nonzero");
   unmap_zero_a: assert property (rd_far_s |=> o_hrdata == 32'h0)
      else $error("unmapped read nonzero");
   rdata_hold_a: assert property (!rd_take |=> $stable(o_hrdata))
      else $error("read data moved without a read");
   dx_stable_a: assert property (bclk_low_s |-> $stable(o_dx))
      else $error("transmit data moved in low bit clock");
   drive_cause_a: assert property ($rose(o_dx_drive) |-> fs_age_q < 6'h28)
      else $error("transmit drive without frame sync");
   reset_idle_a: assert property (disable iff (1'b0) i_rst |=> !o_dx_drive && !o_dx)
      else $error("link not idle after reset");
endmodule
bind spfmt_top spfmt_asserts i_chk (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(i_hsel),
   .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
   .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_hresp(o_hresp), .i_bclk(i_bclk),
   .i_fsx(i_fsx), .o_dx(o_dx), .o_dx_drive(o_dx_drive));
`default_nettype wire

// >>> verif/spfmt_codec.sv
// behavioural serial device: bit clock, frame syncs, receive data, transmit capture
`timescale 1ns/1ps
`default_nettype none
module spfmt_codec (
   // control from the bench
   input wire logic i_go,
   input wire logic [31:0] i_rx_word,
   input wire logic [7:0] i_rx_bits,
   input wire logic [7:0] i_restart,
   // serial link
   output logic o_bclk,
   output logic o_fsx,
   output logic o_fsr,
   output logic o_dr,
   input wire logic i_dx,
   input wire logic i_dx_drive,
   // results of the last frame
   output logic o_busy,
   output logic [63:0] o_cap,
   output logic [7:0] o_ncap,
   output logic [7:0] o_first
);
   int i;
   // bit clock runs only inside a frame and then stands low
   initial begin
      o_bclk = 1'b0;
      o_fsx = 1'b0;
      o_fsr = 1'b0;
      o_dr = 1'b1;
      o_busy = 1'b0;
      o_cap = 64'h0;
      o_ncap = 8'h00;
      o_first = 8'hff;
      forever begin
         @(posedge i_go);
         #37;
         o_busy = 1'b1;
         o_ncap = 8'h00;
         o_first = 8'hff;
         for (i = 0; i < 48; i++) begin
            o_bclk = 1'b1;
            o_fsx = (i == 0) || (i == i_restart);
            o_fsr = (i == 0);
            // idle data toggles so a stale level is never mistaken for data
            o_dr = (i < i_rx_bits) ? i_rx_word[i_rx_bits - 1 - i] : ~o_dr;
            #200;
            o_bclk = 1'b0;
            if (i_dx_drive === 1'b1) begin
               o_cap[o_ncap[5:0]] = i_dx;
               if (o_first == 8'hff) o_first = i[7:0];
               o_ncap = o_ncap + 8'h01;
            end
            #200;
         end
         o_fsx = 1'b0;
         o_fsr = 1'b0;
         o_dr = ~o_dr;
         o_busy = 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> verif/spfmt_top_test.sv
// self-checking bench for the serial port frame-format block
`timescale 1ns/1ps
`default_nettype none
module spfmt_top_test;
   import spfmt_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic go = 1'b0;
   logic [31:0] rxw = 32'h0;
   logic [7:0] rxn = 8'h00;
   logic [7:0] rsat = 8'hff;
   logic [31:0] rd;
   wire hready, hresp, bclk, fsx, fsr, dr, dx, dxd, busy;
   wire [31:0] hrdata;
   wire [63:0] cap;
   wire [7:0] ncap, first;
   int n_errors = 0;
   int n_compared = 0;
   int c;
   int wl[8] = '{8, 12, 16, 20, 24, 32, 8, 8};
   // 50 ns clock
   always #25 clk = ~clk;
   spfmt_top i_dut (.i_clk(clk), .i_rst(rst), .i_hsel(1'b1), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp),
      .i_bclk(bclk), .i_fsx(fsx), .i_fsr(fsr), .i_dr(dr), .o_dx(dx), .o_dx_drive(dxd));
   spfmt_codec i_codec (.i_go(go), .i_rx_word(rxw), .i_rx_bits(rxn), .i_restart(rsat),
      .o_bclk(bclk), .o_fsx(fsx), .o_fsr(fsr), .o_dr(dr), .i_dx(dx), .i_dx_drive(dxd),
      .o_busy(busy), .o_cap(cap), .o_ncap(ncap), .o_first(first));
   // ==========================================================
   // tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      if (n_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // one single ahb-lite transfer, idling one cycle before it
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic frame(input logic [7:0] restart);
      int k;
      rsat <= restart;
      go <= 1'b1;
      repeat (3) @(posedge clk);
      go <= 1'b0;
      for (k = 0; k < 1000 && busy !== 1'b0; k++) @(posedge clk);
      check({31'h0, busy}, 32'h0);
   endtask
   // one transmit frame: bit count, first bit position, first word bits
   task automatic tx_case(input logic [31:0] ctl, input logic [31:0] dat,
         input logic [31:0] ew, input int nb, input int wb, input logic lsb,
         input int fst, input logic [7:0] restart);
      int j;
      ahb(1'b1, OFS_TX_CTRL, ctl);
      ahb(1'b1, OFS_TX_DATA, dat);
      ahb(1'b0, OFS_STATUS, 32'h0);
      check({31'h0, rd[ST_TX_EMPTY]}, 32'h0);
      frame(restart);
      ahb(1'b0, OFS_STATUS, 32'h0);
      check({30'h0, rd[ST_TX_BUSY], rd[ST_TX_EMPTY]}, 32'h1);
      check({24'h0, ncap}, nb);
      check({24'h0, first}, fst);
      for (j = 0; j < wb; j++) check({31'h0, cap[j]}, {31'h0, lsb ? ew[j] : ew[wb - 1 - j]});
   endtask
   task automatic rx_case(input logic [31:0] ctl, input logic [31:0] w, input int n,
         input logic [31:0] exp);
      ahb(1'b1, OFS_RX_CTRL, ctl);
      // drain any word left by earlier frames so the ready check means something
      ahb(1'b0, OFS_RX_DATA, 32'h0);
      ahb(1'b0, OFS_STATUS, 32'h0);
      check({31'h0, rd[ST_RX_READY]}, 32'h0);
      rxw <= w;
      rxn <= n[7:0];
      frame(8'hff);
      rxn <= 8'h00;
      ahb(1'b0, OFS_STATUS, 32'h0);
      check({31'h0, rd[ST_RX_READY]}, 32'h1);
      ahb(1'b0, OFS_RX_DATA, 32'h0);
      check(rd, exp);
   endtask
   function automatic logic [31:0] rev32(input logic [31:0] v);
      for (int b = 0; b < 32; b++) rev32[b] = v[31 - b];
   endfunction
   // ==========================================================
   // watchdog, reckoned at nearly four times the expected run
   initial begin
      #2000000;
      n_errors++;
      $display("ERROR %0t watchdog expired", $time);
      finish_test();
   end
   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      ahb(1'b0, OFS_TX_CTRL, 32'h0);
      check(rd, TX_CTRL_RST);
      ahb(1'b0, OFS_RX_CTRL, 32'h0);
      check(rd, RX_CTRL_RST);
      ahb(1'b1, OFS_TX_CTRL, 32'hffff_ffff);
      ahb(1'b0, OFS_TX_CTRL, 32'h0);
      check(rd, CTRL_WR_MASK);
      ahb(1'b1, OFS_RX_CTRL, 32'hffff_ffff);
      ahb(1'b0, OFS_RX_CTRL, 32'h0);
      check(rd, CTRL_WR_MASK);
      ahb(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0);
      for (c = 0; c < 8; c++) tx_case({c[2:0], 5'h0}, 32'ha5c3_96f1, 32'ha5c3_96f1, wl[c], wl[c], 1'b0, 1, 8'hff);
      tx_case(32'h8140_0000, 32'h0000_005a, 32'h0000_005a, 40, 8, 1'b0, 1, 8'hff);
      tx_case(32'h0140_0000, 32'h0000_005a, 32'h0000_005a, 8, 8, 1'b0, 1, 8'hff);
      tx_case(32'h0000_0200, 32'h0000_005a, 32'h0000_005a, 24, 8, 1'b0, 1, 8'hff);
      tx_case(32'h0008_0000, 32'h0000_0096, 32'h0000_0096, 8, 8, 1'b1, 1, 8'hff);
      tx_case(32'h0010_0000, 32'h0, 32'h0000_00ff, 8, 8, 1'b0, 1, 8'hff);
      tx_case(32'h0018_0000, 32'h0, 32'h0000_00d5, 8, 8, 1'b0, 1, 8'hff);
      tx_case(32'h0010_0040, 32'h0000_96f1, 32'h0000_96f1, 16, 16, 1'b0, 1, 8'hff);
      tx_case(32'h0008_00b0, 32'hc3a5_96e7, 32'hc3a5_96e7, 32, 32, 1'b1, 1, 8'hff);
      for (c = 1; c < 3; c++) tx_case({c[1:0], 16'h0}, 32'h5a, 32'h5a, 8, 8, 1'b0, c + 1, 8'hff);
      tx_case(32'h0000_0300, 32'h0000_005a, 32'h0000_005a, 42, 8, 1'b0, 1, 8'h0a);
      tx_case(32'h0004_0300, 32'h0000_005a, 32'h0000_005a, 32, 8, 1'b0, 1, 8'h0a);
      for (c = 0; c < 6; c++) rx_case({c[2:0], 5'h0}, 32'hc3a5_96e7, wl[c], 32'hc3a5_96e7 & 32'((64'h1 << wl[c]) - 64'h1));
      rx_case(32'h0008_00b0, 32'hc3a5_96e7, 32, rev32(32'hc3a5_96e7));
      finish_test();
   end
endmodule
`default_nettype wire
